// file: rtl/dpio_pkg.sv
// Contract
// R1 - Port A output data is an eight-bit read/write register at 0x02 that resets to zero.
// R2 - Port A pull-up enable is an eight-bit read/write register at 0x03 that resets to zero.
// R3 - Bits 3:0 at 0x04 read the sampled port B pin levels, undefined after reset, upper bits zero.
// R4 - Port B direction is a four-bit read/write field at 0x05 that resets to all inputs.
// R5 - Port B output data is a four-bit read/write field at 0x06 that resets to zero.
// R6 - Port B pull-up enable is a four-bit read/write field at 0x07 that resets to zero.
// R7 - Control bit 1 at 0x16 turns on break-before-make for all of port B and resets to zero.
// R8 - Control bit 0 at 0x16 turns on break-before-make for all of port A and resets to zero.
// R9 - With break-before-make on, a pin switched to output is tristated one cycle before driving.
// R10 - A direction of one drives the data bit; zero leaves an input, pulled up only if enabled.
package dpio_pkg;
    // =========================================
    // Register map
    localparam logic [7:0] ADDR_PA_OUT = 8'h02;
    localparam logic [7:0] ADDR_PA_PUE = 8'h03;
    localparam logic [7:0] ADDR_PB_PIN = 8'h04;
    localparam logic [7:0] ADDR_PB_DIR = 8'h05;
    localparam logic [7:0] ADDR_PB_OUT = 8'h06;
    localparam logic [7:0] ADDR_PB_PUE = 8'h07;
    localparam logic [7:0] ADDR_PCTRL = 8'h16;
    // =========================================
    // Fields and reset values
    localparam int BIT_BBM_A = 0;
    localparam int BIT_BBM_B = 1;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int PA_WIDTH = 8;
    localparam int PB_WIDTH = 4;
    // Port A direction is held outside this block; the value it assumes is given here
    localparam logic [7:0] PA_DIR_DEFAULT = 8'h00;
endpackage

// file: rtl/dpio_bank.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module dpio_bank #(
    parameter int PA_W = dpio_pkg::PA_WIDTH,
    parameter int PB_W = dpio_pkg::PB_WIDTH
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Port A pins; direction comes from the port A direction register outside
    input wire logic [PA_W-1:0] pa_dir_in,
    output logic [PA_W-1:0] pa_pin_out,
    output logic [PA_W-1:0] pa_pin_oe_out,
    output logic [PA_W-1:0] pa_pullup_out,
    // Port B pins
    input wire logic [PB_W-1:0] pb_pin_in,
    output logic [PB_W-1:0] pb_pin_out,
    output logic [PB_W-1:0] pb_pin_oe_out,
    output logic [PB_W-1:0] pb_pullup_out
);
    // =========================================
    // Storage
    logic [PA_W-1:0] port_a_output_data;
    logic [PA_W-1:0] port_a_pullup_enable;
    logic [PB_W-1:0] port_b_pin_level;
    logic [PB_W-1:0] port_b_direction;
    logic [PB_W-1:0] port_b_output_data;
    logic [PB_W-1:0] port_b_pullup_enable;
    logic first_port_bbm_enable;
    logic second_port_bbm_enable;
    logic [PA_W-1:0] pa_dir_q;
    logic [PB_W-1:0] pb_dir_q;
    logic [PA_W-1:0] pa_drive;
    logic [PB_W-1:0] pb_drive;

    // =========================================
    // Decode
    wire wr_pa_out = wr_in && (addr_in == dpio_pkg::ADDR_PA_OUT);
    wire wr_pa_pue = wr_in && (addr_in == dpio_pkg::ADDR_PA_PUE);
    wire wr_pb_dir = wr_in && (addr_in == dpio_pkg::ADDR_PB_DIR);
    wire wr_pb_out = wr_in && (addr_in == dpio_pkg::ADDR_PB_OUT);
    wire wr_pb_pue = wr_in && (addr_in == dpio_pkg::ADDR_PB_PUE);
    wire wr_pctrl = wr_in && (addr_in == dpio_pkg::ADDR_PCTRL);

    // Pad up to a byte; upper bits read zero
    function automatic logic [7:0] pad_b(input logic [PB_W-1:0] v);
        pad_b = {{(8-PB_W){1'b0}}, v};
    endfunction

    // Read mux, unmapped addresses read zero
    wire [7:0] rd_mux =
        (addr_in == dpio_pkg::ADDR_PA_OUT) ? 8'(port_a_output_data) :
        (addr_in == dpio_pkg::ADDR_PA_PUE) ? 8'(port_a_pullup_enable) :
        (addr_in == dpio_pkg::ADDR_PB_PIN) ? pad_b(port_b_pin_level) : // [R3]
        (addr_in == dpio_pkg::ADDR_PB_DIR) ? pad_b(port_b_direction) :
        (addr_in == dpio_pkg::ADDR_PB_OUT) ? pad_b(port_b_output_data) :
        (addr_in == dpio_pkg::ADDR_PB_PUE) ? pad_b(port_b_pullup_enable) :
        (addr_in == dpio_pkg::ADDR_PCTRL) ?
            {6'h00, second_port_bbm_enable, first_port_bbm_enable} : 8'h00;

    // =========================================
    // Register writes
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            port_a_output_data <= PA_W'(dpio_pkg::RESET_VALUE); // [R1]
            port_a_pullup_enable <= PA_W'(dpio_pkg::RESET_VALUE); // [R2]
            port_b_direction <= PB_W'(dpio_pkg::RESET_VALUE); // [R4]
            port_b_output_data <= PB_W'(dpio_pkg::RESET_VALUE); // [R5]
            port_b_pullup_enable <= PB_W'(dpio_pkg::RESET_VALUE); // [R6]
            first_port_bbm_enable <= 1'b0; // [R8]
            second_port_bbm_enable <= 1'b0; // [R7]
            rdata_out <= 8'h00;
        end
        else
        begin
            if (wr_pa_out) port_a_output_data <= wdata_in[PA_W-1:0]; // [R1]
            if (wr_pa_pue) port_a_pullup_enable <= wdata_in[PA_W-1:0]; // [R2]
            if (wr_pb_dir) port_b_direction <= wdata_in[PB_W-1:0]; // [R4]
            if (wr_pb_out) port_b_output_data <= wdata_in[PB_W-1:0]; // [R5]
            if (wr_pb_pue) port_b_pullup_enable <= wdata_in[PB_W-1:0]; // [R6]
            if (wr_pctrl)
            begin
                first_port_bbm_enable <= wdata_in[dpio_pkg::BIT_BBM_A]; // [R8]
                second_port_bbm_enable <= wdata_in[dpio_pkg::BIT_BBM_B]; // [R7]
            end
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end

    // Pin sampling has no reset: the level is undefined until the first edge
    always_ff @(posedge clock_in)
    begin
        port_b_pin_level <= pb_pin_in; // [R3]
    end

    // Last direction, used to spot a fresh switch to output
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            pa_dir_q <= PA_W'(dpio_pkg::PA_DIR_DEFAULT);
            pb_dir_q <= PB_W'(dpio_pkg::RESET_VALUE);
        end
        else
        begin
            pa_dir_q <= pa_dir_in;
            pb_dir_q <= port_b_direction;
        end
    end

    // =========================================
    // Pin drive; one tristate cycle on a rising direction bit in bbm mode
    assign pa_drive = pa_dir_in & ~(first_port_bbm_enable ? (pa_dir_in & ~pa_dir_q) : '0); // [R9]
    assign pb_drive = port_b_direction &
        ~(second_port_bbm_enable ? (port_b_direction & ~pb_dir_q) : '0); // [R9]
    assign pa_pin_oe_out = pa_drive; // [R10]
    assign pa_pin_out = port_a_output_data & pa_drive;
    assign pa_pullup_out = port_a_pullup_enable & ~pa_dir_in; // [R10]
    assign pb_pin_oe_out = pb_drive; // [R10]
    assign pb_pin_out = port_b_output_data & pb_drive;
    assign pb_pullup_out = port_b_pullup_enable & ~port_b_direction; // [R10]

    // =========================================
    // Checks
    property p_bbm_b;
        @(posedge clock_in) disable iff (!rstn_in)
        (second_port_bbm_enable && $rose(port_b_direction[0])) |-> !pb_pin_oe_out[0];
    endproperty
    a_bbm_b: assert property (p_bbm_b) else $error("bbm gap missing on B0"); // [R9]

    property p_nobbm_b;
        @(posedge clock_in) disable iff (!rstn_in)
        (!second_port_bbm_enable && port_b_direction[0]) |-> pb_pin_oe_out[0];
    endproperty
    a_nobbm_b: assert property (p_nobbm_b) else $error("B0 not driven"); // [R7]

    property p_bbm_a;
        @(posedge clock_in) disable iff (!rstn_in)
        (first_port_bbm_enable && $rose(pa_dir_in[0])) |-> !pa_pin_oe_out[0];
    endproperty
    a_bbm_a: assert property (p_bbm_a) else $error("bbm gap missing on A0"); // [R8]

    property p_bbm_drive;
        @(posedge clock_in) disable iff (!rstn_in)
        $rose(port_b_direction[1]) ##1 port_b_direction[1] |-> pb_pin_oe_out[1];
    endproperty
    a_bbm_drive: assert property (p_bbm_drive) else $error("B1 not driven after gap"); // [R9]

    property p_pa_out;
        @(posedge clock_in) disable iff (!rstn_in)
        wr_pa_out |=> port_a_output_data == $past(wdata_in);
    endproperty
    a_pa_out: assert property (p_pa_out) else $error("port A data not written"); // [R1]

    property p_pa_pue;
        @(posedge clock_in) disable iff (!rstn_in)
        (rd_in && addr_in == dpio_pkg::ADDR_PA_PUE) |=> rdata_out == port_a_pullup_enable;
    endproperty
    a_pa_pue: assert property (p_pa_pue) else $error("pull-up readback wrong"); // [R2]

    property p_pin_rd;
        @(posedge clock_in) disable iff (!rstn_in)
        (rd_in && addr_in == dpio_pkg::ADDR_PB_PIN) |=> rdata_out[7:4] == 4'h0;
    endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("pin level upper bits set"); // [R3]

    property p_pb_dir;
        @(posedge clock_in) disable iff (!rstn_in)
        wr_pb_dir |=> port_b_direction == $past(wdata_in[3:0]);
    endproperty
    a_pb_dir: assert property (p_pb_dir) else $error("direction not written"); // [R4]

    property p_pb_val;
        @(posedge clock_in) disable iff (!rstn_in)
        pb_pin_oe_out[2] |-> pb_pin_out[2] == port_b_output_data[2];
    endproperty
    a_pb_val: assert property (p_pb_val) else $error("B2 drives wrong value"); // [R5]

    property p_pue;
        @(posedge clock_in) disable iff (!rstn_in)
        pb_pullup_out[3] |-> port_b_pullup_enable[3] && !port_b_direction[3];
    endproperty
    a_pue: assert property (p_pue) else $error("pull-up on output or disabled"); // [R6]

    // =========================================
    // Reset and write checks on the remaining registers
    property p_rst_regs;
        @(posedge clock_in)
        !rstn_in |=> (port_a_output_data == '0) && (port_a_pullup_enable == '0) &&
            (port_b_direction == '0) && (port_b_output_data == '0) &&
            (port_b_pullup_enable == '0);
    endproperty
    a_rst_regs: assert property (p_rst_regs) else $error("register not cleared"); // [R5]

    // Both mode bits must come out of reset off, or a pin could glitch at power-up
    property p_rst_ctrl;
        @(posedge clock_in)
        !rstn_in |=> !first_port_bbm_enable && !second_port_bbm_enable;
    endproperty
    a_rst_ctrl: assert property (p_rst_ctrl) else $error("mode bits not cleared"); // [R7][R8]

    property p_pb_out;
        @(posedge clock_in) disable iff (!rstn_in)
        wr_pb_out |=> port_b_output_data == $past(wdata_in[PB_W-1:0]);
    endproperty
    a_pb_out: assert property (p_pb_out) else $error("port B data not written"); // [R5]

    property p_pb_pue;
        @(posedge clock_in) disable iff (!rstn_in)
        wr_pb_pue |=> port_b_pullup_enable == $past(wdata_in[PB_W-1:0]);
    endproperty
    a_pb_pue: assert property (p_pb_pue) else $error("port B pull-up not written"); // [R6]

    property p_pa_pue_wr;
        @(posedge clock_in) disable iff (!rstn_in)
        wr_pa_pue |=> port_a_pullup_enable == $past(wdata_in[PA_W-1:0]);
    endproperty
    a_pa_pue_wr: assert property (p_pa_pue_wr) else $error("port A pull-up not written"); // [R2]

    // Only the two low bits of the control byte exist; the rest must be dropped
    property p_pctrl;
        @(posedge clock_in) disable iff (!rstn_in)
        wr_pctrl |=> {second_port_bbm_enable, first_port_bbm_enable} == $past(wdata_in[1:0]);
    endproperty
    a_pctrl: assert property (p_pctrl) else $error("mode bits not written"); // [R7]

    // Read data stand for one cycle only, so an idle bus must read zero
    property p_rd_idle;
        @(posedge clock_in) disable iff (!rstn_in)
        !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read"); // [R1]

    property p_pin_level;
        @(posedge clock_in) disable iff (!rstn_in)
        (rd_in && addr_in == dpio_pkg::ADDR_PB_PIN) |=>
            rdata_out[PB_W-1:0] == $past(port_b_pin_level);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level readback wrong"); // [R3]

    // =========================================
    // Per-pin checks on port B; every pin carries the same guarantees
    generate
        for (genvar gi = 0; gi < PB_W; gi++)
        begin : g_pb_chk
            property p_gap_b;
                @(posedge clock_in) disable iff (!rstn_in)
                (second_port_bbm_enable && port_b_direction[gi] && !pb_dir_q[gi]) |->
                    !pb_pin_oe_out[gi];
            endproperty
            a_gap_b: assert property (p_gap_b) else $error("port B gap missing"); // [R9]

            property p_held_b;
                @(posedge clock_in) disable iff (!rstn_in)
                (port_b_direction[gi] && pb_dir_q[gi]) |-> pb_pin_oe_out[gi];
            endproperty
            a_held_b: assert property (p_held_b) else $error("port B output dropped"); // [R10]

            property p_in_b;
                @(posedge clock_in) disable iff (!rstn_in)
                !port_b_direction[gi] |-> !pb_pin_oe_out[gi] && !pb_pin_out[gi];
            endproperty
            a_in_b: assert property (p_in_b) else $error("port B input driven"); // [R10]

            property p_pull_b;
                @(posedge clock_in) disable iff (!rstn_in)
                pb_pullup_out[gi] == (port_b_pullup_enable[gi] && !port_b_direction[gi]);
            endproperty
            a_pull_b: assert property (p_pull_b) else $error("port B pull-up wrong"); // [R6]
        end
    endgenerate

    // =========================================
    // Per-pin checks on port A; direction comes in from outside, so each pin is watched
    generate
        for (genvar gj = 0; gj < PA_W; gj++)
        begin : g_pa_chk
            property p_gap_a;
                @(posedge clock_in) disable iff (!rstn_in)
                (first_port_bbm_enable && pa_dir_in[gj] && !pa_dir_q[gj]) |->
                    !pa_pin_oe_out[gj];
            endproperty
            a_gap_a: assert property (p_gap_a) else $error("port A gap missing"); // [R9]

            property p_held_a;
                @(posedge clock_in) disable iff (!rstn_in)
                (pa_dir_in[gj] && pa_dir_q[gj]) |->
                    pa_pin_oe_out[gj] && (pa_pin_out[gj] == port_a_output_data[gj]);
            endproperty
            a_held_a: assert property (p_held_a) else $error("port A drive wrong"); // [R10]

            property p_in_a;
                @(posedge clock_in) disable iff (!rstn_in)
                !pa_dir_in[gj] |-> !pa_pin_oe_out[gj] && !pa_pin_out[gj];
            endproperty
            a_in_a: assert property (p_in_a) else $error("port A input driven"); // [R10]

            property p_pull_a;
                @(posedge clock_in) disable iff (!rstn_in)
                pa_pullup_out[gj] == (port_a_pullup_enable[gj] && !pa_dir_in[gj]);
            endproperty
            a_pull_a: assert property (p_pull_a) else $error("port A pull-up wrong"); // [R2]
        end
    endgenerate

    // Scenarios worth seeing: both modes switched on, and a pin driven after its gap
    c_wr_pctrl: cover property (@(posedge clock_in) wr_pctrl && wdata_in[1] && wdata_in[0]);
    c_gap_done: cover property (@(posedge clock_in) second_port_bbm_enable &&
        $rose(pb_pin_oe_out[0]));

    c_bbm_b: cover property (@(posedge clock_in) second_port_bbm_enable &&
        $rose(port_b_direction[0]));
    c_bbm_a: cover property (@(posedge clock_in) first_port_bbm_enable && $rose(pa_dir_in[0]));
    c_rd_pin: cover property (@(posedge clock_in) rd_in && addr_in == dpio_pkg::ADDR_PB_PIN);
endmodule

// file: verif/tb_dpio_bank.sv
`timescale 1ns/10ps
module tb_dpio_bank;
    // =====================================
    // Stimulus and observed signals
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] pa_dir_in = 8'h00;
    logic [3:0] pb_pin_in = 4'h0;
    logic [7:0] rdata_out, pa_pin_out, pa_pin_oe_out, pa_pullup_out;
    logic [3:0] pb_pin_out, pb_pin_oe_out, pb_pullup_out;
    int fail_count = 0;
    int check_count = 0;
    // Writable registers, their implemented bits and the bench's copy of them
    logic [7:0] adr[6] = '{dpio_pkg::ADDR_PA_OUT, dpio_pkg::ADDR_PA_PUE, dpio_pkg::ADDR_PB_DIR,
        dpio_pkg::ADDR_PB_OUT, dpio_pkg::ADDR_PB_PUE, dpio_pkg::ADDR_PCTRL};
    logic [7:0] mask[6] = '{8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'h03};
    logic [7:0] mir[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    dpio_bank dpio_bank_inst (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .pa_dir_in(pa_dir_in), .pa_pin_out(pa_pin_out), .pa_pin_oe_out(pa_pin_oe_out),
        .pa_pullup_out(pa_pullup_out), .pb_pin_in(pb_pin_in), .pb_pin_out(pb_pin_out),
        .pb_pin_oe_out(pb_pin_oe_out), .pb_pullup_out(pb_pullup_out));

    // 125 MHz clock
    always #4 clock_in = ~clock_in;

    // =====================================
    // Expectations and bus tasks
    function automatic logic [7:0] exp_drive(input logic [7:0] data, input logic [7:0] dir);
        return data & dir;
    endfunction

    function automatic logic [7:0] exp_pull(input logic [7:0] pue, input logic [7:0] dir);
        return pue & ~dir;
    endfunction

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        cmp("rdata", exp, rdata_out);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard: no handshake waits exist, but cut the run short regardless
    initial
    begin
        #400000;
        fail_count++;
        close_out();
    end

    // =====================================
    // Main sequence
    initial
    begin
        int k;
        void'($urandom(38664));
        repeat (12) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(adr[i], 8'h00);
        // Random writes with readback; pins and pad controls follow the copy
        for (int i = 0; i < 30; i++)
        begin
            k = (i < 6) ? i : int'($urandom_range(5, 0));
            @(posedge clock_in);
            pa_dir_in <= 8'($urandom);
            pb_pin_in <= 4'($urandom);
            wr(adr[k], (i < 6) ? 8'hFF : 8'($urandom));
            mir[k] = ((i < 6) ? 8'hFF : wdata_in) & mask[k];
            rd_chk(adr[k], mir[k]);
            rd_chk(dpio_pkg::ADDR_PB_PIN, {4'h0, pb_pin_in});
            cmp("pa_oe", pa_dir_in, pa_pin_oe_out);
            cmp("pa_pin", exp_drive(mir[0], pa_dir_in), pa_pin_out);
            cmp("pa_pull", exp_pull(mir[1], pa_dir_in), pa_pullup_out);
            cmp("pb_oe", mir[2], {4'h0, pb_pin_oe_out});
            cmp("pb_pin", exp_drive(mir[3], mir[2]), {4'h0, pb_pin_out});
            cmp("pb_pull", exp_pull(mir[4], mir[2]) & 8'h0F, {4'h0, pb_pullup_out});
        end
        // Unmapped place: write ignored, reads zero
        wr(8'h08, 8'hFF);
        rd_chk(8'h08, 8'h00);
        // Port B: immediate drive with the mode off, one tristate cycle with it on
        wr(dpio_pkg::ADDR_PCTRL, 8'h00);
        wr(dpio_pkg::ADDR_PB_DIR, 8'h00);
        wr(dpio_pkg::ADDR_PB_DIR, 8'h01);
        #1;
        cmp("pb_oe", 8'h01, {4'h0, pb_pin_oe_out});
        wr(dpio_pkg::ADDR_PB_DIR, 8'h00);
        wr(dpio_pkg::ADDR_PCTRL, 8'h02);
        wr(dpio_pkg::ADDR_PB_DIR, 8'h01);
        #1;
        cmp("pb_oe", 8'h00, {4'h0, pb_pin_oe_out});
        @(posedge clock_in);
        #1;
        cmp("pb_oe", 8'h01, {4'h0, pb_pin_oe_out});
        // Port A: direction input rises with its mode on
        @(posedge clock_in);
        pa_dir_in <= 8'h00;
        wr(dpio_pkg::ADDR_PCTRL, 8'h01);
        pa_dir_in <= 8'h01;
        #1;
        cmp("pa_oe", 8'h00, pa_pin_oe_out);
        @(posedge clock_in);
        #1;
        cmp("pa_oe", 8'h01, pa_pin_oe_out);
        close_out();
    end
endmodule
